/* bench/fmes_array_model.sv */
`timescale 1ns/10ps
module fmes_array_model
    import fmes_pkg::*;
#(
    parameter int WORDS = 8
) (
    input wire logic clk_in, // Clock shared with the sequencer.
    input wire fmes_pkg::fmes_array_req_t req_in, // Erase and read strobes.
    output logic [15:0] rdata_out // Word, the cycle after a read strobe.
);
    logic [15:0] mem_q [WORDS];
    initial begin
        rdata_out = 16'h0000;
        for (int i = 0; i < WORDS; i++) begin
            mem_q[i] = 16'h1234 + 16'(i);
        end
    end
    // Outside a read slot the word flips each clock, so a stale value never passes for data.
    always @(posedge clk_in) begin
        if (req_in.erase) begin
            mem_q[req_in.addr] <= 16'hFFFF;
        end
        if (req_in.read) begin
            rdata_out <= mem_q[req_in.addr];
        end else begin
            rdata_out <= ~rdata_out;
        end
    end
endmodule

/* bench/fmes_properties.sv */
`timescale 1ns/10ps
module fmes_checker
    import fmes_pkg::*;
#(
    parameter int ARRAY_WORDS = 8
) (
    input wire logic core_clk_in, // Clock.
    input wire logic reset_n_in, // Reset, active low.
    input wire fmes_pkg::fmes_bus_req_t bus_in, // Bus request.
    input wire logic [7:0] rdata_out, // Read data.
    input wire logic special_mode_in, // Special mode.
    input wire logic cpu_stop_in, // Processor stop.
    input wire logic [15:0] array_rdata_in, // Array word.
    input wire fmes_pkg::fmes_array_req_t array_out, // Array strobes.
    input wire logic irq_out // Interrupt.
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);
    int run_q;
    int since_q;
    // The launch distance saturates so that a long idle stretch cannot wrap into a false match.
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            run_q <= 0;
            since_q <= 100;
        end else begin
            run_q <= array_out.erase ? run_q + 1 : 0;
            if (bus_in.wr && bus_in.addr == 16'h0005 && bus_in.wdata[7]) begin
                since_q <= 0;
            end else if (since_q < 100) begin
                since_q <= since_q + 1;
            end
        end
    end
    property p_cmd_rsvd;
        bus_in.rd && bus_in.addr == 16'h0006 |=> (rdata_out & 8'h9A) == 8'h00;
    endproperty
    a_cmd_rsvd: assert property (p_cmd_rsvd) else $error("reserved command bits not zero");
    property p_rdata_idle;
        !$past(bus_in.rd) |-> rdata_out == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
    property p_erase_first;
        $rose(array_out.erase) |-> array_out.addr == 15'h0000;
    endproperty
    a_erase_first: assert property (p_erase_first) else $error("erase walk not from word zero");
    property p_erase_step;
        array_out.erase && $past(array_out.erase) |-> array_out.addr == $past(array_out.addr) + 15'h0001;
    endproperty
    a_erase_step: assert property (p_erase_step) else $error("erase walk skipped a word");
    property p_erase_count;
        $fell(array_out.erase) |-> run_q == ARRAY_WORDS;
    endproperty
    a_erase_count: assert property (p_erase_count) else $error("erase pulse count wrong");
    property p_erase_launch;
        $rose(array_out.erase) |-> since_q <= 6;
    endproperty
    a_erase_launch: assert property (p_erase_launch) else $error("erase without launch write");
    property p_erase_excl;
        array_out.erase |-> !array_out.read;
    endproperty
    a_erase_excl: assert property (p_erase_excl) else $error("erase and read together");
    property p_verify_first;
        $rose(array_out.read) |-> array_out.addr == 15'h0000;
    endproperty
    a_verify_first: assert property (p_verify_first) else $error("verify not from word zero");
    property p_done_low;
        bus_in.rd && bus_in.addr == 16'h0005 && array_out.erase && array_out.addr != 15'(ARRAY_WORDS - 1)
            |=> !rdata_out[0];
    endproperty
    a_done_low: assert property (p_done_low) else $error("done bit high while erasing");
endmodule

bind fmes_top fmes_checker #(.ARRAY_WORDS(ARRAY_WORDS)) u_checker (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .bus_in(bus_in),
    .rdata_out(rdata_out),
    .special_mode_in(special_mode_in),
    .cpu_stop_in(cpu_stop_in),
    .array_rdata_in(array_rdata_in),
    .array_out(array_out),
    .irq_out(irq_out)
);

/* bench/testbench.sv */
`timescale 1ns/10ps
module testbench;
    import fmes_pkg::*;
    logic core_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    fmes_bus_req_t bus_q = '0;
    logic special_q = 1'b0;
    logic stop_q = 1'b0;
    logic [7:0] rdata;
    logic [15:0] arr_rdata;
    fmes_array_req_t arr_req;
    logic irq;
    logic [7:0] got;
    int fail_count = 0;
    int num_checks = 0;

    initial begin
        forever #5 core_clk_in = ~core_clk_in;
    end

    fmes_top #(.ARRAY_WORDS(8)) u_dut (
        .core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .bus_in(bus_q),
        .rdata_out(rdata),
        .special_mode_in(special_q),
        .cpu_stop_in(stop_q),
        .array_rdata_in(arr_rdata),
        .array_out(arr_req),
        .irq_out(irq)
    );
    fmes_array_model #(.WORDS(8)) u_array (.clk_in(core_clk_in), .req_in(arr_req), .rdata_out(arr_rdata));

    task automatic summarize();
        if (fail_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] seen);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        bus_q <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk_in);
        bus_q.wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a);
        @(posedge core_clk_in);
        bus_q <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk_in);
        bus_q.rd <= 1'b0;
        #1 got = rdata;
    endtask
    task automatic stat(input logic [7:0] exp);
        rd(16'h0005);
        check("flash_status", {8'h00, exp}, {8'h00, got});
    endtask
    task automatic irq_chk(input logic exp);
        @(posedge core_clk_in);
        #1 check("irq_out", {15'h0000, exp}, {15'h0000, irq});
    endtask
    task automatic launch(input logic [7:0] code);
        wr(16'h4005, 8'hA5);
        wr(16'h0006, code);
        wr(16'h0005, 8'h80);
    endtask
    task automatic wait_done();
        rd(16'h0005);
        check("busy_status", 16'h0000, {8'h00, got & 8'h41});
        for (int i = 0; i < 100 && !got[6]; i++) begin
            rd(16'h0005);
        end
        if (!got[6]) begin
            fail_count++;
            $display("unexpected completion: expected 1 seen 0");
            summarize();
        end
    endtask

    task automatic s_reset();
        stat(8'hC0);
        rd(16'h0006);
        check("flash_command", 16'h0000, {8'h00, got});
    endtask
    task automatic s_mass_erase();
        wr(16'h0009, 8'h01);
        launch(8'h41);
        wait_done();
        for (int i = 0; i < 8; i++) begin
            check("array_word", 16'hFFFF, u_array.mem_q[i]);
        end
        stat(8'hC1);
        irq_chk(1'b1);
        wr(16'h0009, 8'h00);
        irq_chk(1'b0);
        rd(16'h0008);
        check("irq_status", 16'h0003, {8'h00, got});
        wr(16'h0008, 8'h07);
        wr(16'h0009, 8'h01);
        irq_chk(1'b0);
    endtask
    task automatic s_verify();
        launch(8'h05);
        wait_done();
        stat(8'hC5);
        u_array.mem_q[3] = 16'h0000;
        launch(8'h05);
        wait_done();
        stat(8'hC3);
        launch(8'h41);
        repeat (20) @(posedge core_clk_in);
        check("array_word", 16'h0000, u_array.mem_q[3]);
        wr(16'h0005, 8'h00);
        stat(8'hC3);
        wr(16'h0005, 8'h02);
        stat(8'hC1);
        @(posedge core_clk_in);
        special_q <= 1'b0;
        repeat (3) @(posedge core_clk_in);
        launch(8'h05);
        wait_done();
        stat(8'hC0);
        @(posedge core_clk_in);
        special_q <= 1'b1;
        repeat (3) @(posedge core_clk_in);
    endtask
    task automatic s_protect();
        wr(16'h0004, 8'h01);
        launch(8'h41);
        stat(8'hE1);
        launch(8'h41);
        repeat (20) @(posedge core_clk_in);
        check("array_word", 16'h0000, u_array.mem_q[3]);
        wr(16'h0005, 8'h00);
        stat(8'hE1);
        wr(16'h0005, 8'h20);
        stat(8'hC1);
        wr(16'h0004, 8'h00);
    endtask
    task automatic s_access();
        wr(16'h0006, 8'h41);
        stat(8'hD1);
        wr(16'h0005, 8'h00);
        stat(8'hD1);
        wr(16'h0005, 8'h10);
        stat(8'hC1);
        wr(16'h4000, 8'h00);
        wr(16'h0006, 8'h01);
        stat(8'hD1);
        wr(16'h0005, 8'h10);
        launch(8'h41);
        @(posedge core_clk_in);
        stop_q <= 1'b1;
        @(posedge core_clk_in);
        stop_q <= 1'b0;
        wait_done();
        stat(8'hD1);
        check("array_word", 16'hFFFF, u_array.mem_q[3]);
        wr(16'h0005, 8'h10);
    endtask

    initial begin
        repeat (8) @(posedge core_clk_in);
        reset_n_in <= 1'b1;
        s_reset();
        @(posedge core_clk_in);
        special_q <= 1'b1;
        repeat (3) @(posedge core_clk_in);
        s_mass_erase();
        s_verify();
        s_protect();
        s_access();
        summarize();
    end
endmodule

/* common/fmes_pkg.sv */
package fmes_pkg;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_ADDR = 2'b01,
        SEQ_CMD = 2'b11
    } fmes_seq_t;

    typedef enum logic [1:0] {
        ENG_IDLE = 2'b00,
        ENG_ERASE = 2'b01,
        ENG_VERIFY = 2'b11,
        ENG_VLAST = 2'b10
    } fmes_eng_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } fmes_bus_req_t;

    typedef struct packed {
        logic [14:0] addr;
        logic erase;
        logic read;
    } fmes_array_req_t;

endpackage

/* common/fmes_regs.svh */
`ifndef FMES_REGS_SVH
`define FMES_REGS_SVH

`define FMES_OFF_PROT 16'h0004
`define FMES_OFF_STAT 16'h0005
`define FMES_OFF_CMD 16'h0006
`define FMES_OFF_IRQ_STAT 16'h0008
`define FMES_OFF_IRQ_MASK 16'h0009
`define FMES_REG_SPAN_MASK 16'hFFF0
`define FMES_ARRAY_BASE 16'h4000

`define FMES_ST_CBE 7
`define FMES_ST_CC 6
`define FMES_ST_PV 5
`define FMES_ST_AE 4
`define FMES_ST_BLANK 2
`define FMES_ST_FAIL 1
`define FMES_ST_DONE 0

`define FMES_CMD_MASS_ERASE 8'h41
`define FMES_CMD_ERASE_VERIFY 8'h05
`define FMES_CMD_WR_MASK 8'h65

`define FMES_IRQ_CC 0
`define FMES_IRQ_CBE 1
`define FMES_IRQ_ERR 2

`define FMES_RST_CMD 8'h00
`define FMES_RST_PROT 8'h00
`define FMES_RST_IRQ 3'h0
`define FMES_ERASED_WORD 16'hFFFF
`define FMES_ARRAY_WORDS 32768

`endif

/* hdl/fmes_top.sv */
`timescale 1ns/10ps
`include "fmes_regs.svh"

// Behaviour
// - Mass erase clears every array location.
// - First write anywhere in array; contents ignored.
// - Writing one to buffer-empty flag launches.
// - Protected area: flag violation, no erase.
// - Complete flag sets unless command buffered.
// - Violation flag bit 5, write-one clears.
// - Violation flag set blocks any launch.
// - Access error on sequence, command, stop faults.
// - Access error write-one clears, blocks launch.
// - Blank flag set by verify, cleared on launch.
// - Blank zero after verify means not erased.
// - Special mode verify miss sets failure flag.
// - Failure flag write-one clears, blocks launch.
// - Done bit low while operation runs; here it rises during the last erase pulse.
// - Command bits 6,5,2,0 writable, others zero.
// - Command register at offset 0x0006.
// - Any array address starts mass erase.
module fmes_top #(
    parameter int ARRAY_WORDS = `FMES_ARRAY_WORDS
) (
    input wire logic core_clk_in, // System clock, 100 MHz.
    input wire logic reset_n_in, // Synchronous reset, active low.
    input wire fmes_pkg::fmes_bus_req_t bus_in, // Register and array write port.
    output logic [7:0] rdata_out, // Read data, cycle after read strobe.
    input wire logic special_mode_in, // Special mode pin, asynchronous.
    input wire logic cpu_stop_in, // Processor stop executing, same clock.
    input wire logic [15:0] array_rdata_in, // Array word, cycle after read.
    output fmes_pkg::fmes_array_req_t array_out, // Array erase and read strobes.
    output logic irq_out // Level interrupt, active high.
);
    import fmes_pkg::*;

    localparam logic [14:0] LAST_WORD = 15'(ARRAY_WORDS - 1);

    function automatic logic is_reg(input logic [15:0] a, input logic [15:0] off);
        is_reg = (a == off);
    endfunction

    function automatic logic is_array(input logic [15:0] a);
        is_array = (a >= `FMES_ARRAY_BASE);
    endfunction

    fmes_seq_t seq_q;
    fmes_eng_t eng_q;
    logic [7:0] cmd_q;
    logic [7:0] prot_q;
    logic cbe_q;
    logic cc_q;
    logic pv_q;
    logic ae_q;
    logic blank_q;
    logic fail_q;
    logic pend_q;
    logic [7:0] pend_cmd_q;
    logic [14:0] walk_q;
    logic rd_vld_q;
    logic all_erased_q;
    logic verify_run_q;
    logic [2:0] irq_stat_q;
    logic [2:0] irq_mask_q;
    logic [7:0] rdata_q;
    logic spec_meta_q;
    logic spec_q;
    fmes_array_req_t arr_q;

    logic wr_arr;
    logic wr_cmd;
    logic wr_stat;
    logic wr_prot;
    logic launch_try;
    logic blocked;
    logic launch_ok;
    logic launch_pv;
    logic seq_err;
    logic cmd_legal;
    logic take;
    logic eng_done;
    logic verify_miss;
    logic stop_err;
    logic ae_set;
    logic pv_set;
    logic fail_set;
    logic cc_set;
    logic cbe_set;
    logic [7:0] status;

    // The special mode pin is asynchronous; only the second stage is read.
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            spec_meta_q <= 1'b0;
            spec_q <= 1'b0;
        end else begin
            spec_meta_q <= special_mode_in;
            spec_q <= spec_meta_q;
        end
    end

    assign wr_arr = bus_in.wr && is_array(bus_in.addr);
    assign wr_cmd = bus_in.wr && is_reg(bus_in.addr, `FMES_OFF_CMD);
    assign wr_stat = bus_in.wr && is_reg(bus_in.addr, `FMES_OFF_STAT);
    assign wr_prot = bus_in.wr && is_reg(bus_in.addr, `FMES_OFF_PROT);

    assign cmd_legal = (bus_in.wdata == `FMES_CMD_MASS_ERASE) || (bus_in.wdata == `FMES_CMD_ERASE_VERIFY);
    assign launch_try = wr_stat && bus_in.wdata[`FMES_ST_CBE];
    assign blocked = pv_q || ae_q || fail_q;
    // A mass erase over any protected area is stopped before it reaches the engine.
    assign launch_pv = launch_try && !blocked && (seq_q == SEQ_CMD)
                       && (cmd_q == `FMES_CMD_MASS_ERASE) && (prot_q != 8'h00);
    assign launch_ok = launch_try && !blocked && (seq_q == SEQ_CMD) && !launch_pv;

    // Broken order, illegal code or launch without a complete sequence.
    assign seq_err = (wr_arr && (!cbe_q || seq_q != SEQ_IDLE) && !blocked)
                     || (wr_cmd && seq_q != SEQ_ADDR && !blocked)
                     || (wr_cmd && seq_q == SEQ_ADDR && !cmd_legal && !blocked)
                     || (launch_try && seq_q != SEQ_CMD && !blocked);
    assign stop_err = cpu_stop_in && !cc_q;

    assign take = (eng_q == ENG_IDLE) && pend_q;
    assign verify_miss = rd_vld_q && (array_rdata_in != `FMES_ERASED_WORD);

    // The last verify word lands two cycles after its walk state, so ENG_VLAST holds until its strobe has gone.
    always_comb begin
        eng_done = 1'b0;
        case (eng_q)
            ENG_ERASE: eng_done = (walk_q == LAST_WORD);
            ENG_VLAST: eng_done = !arr_q.read;
            default: eng_done = 1'b0;
        endcase
    end

    assign ae_set = seq_err || stop_err;
    assign pv_set = launch_pv;
    assign fail_set = eng_done && verify_run_q && spec_q && !(all_erased_q && !verify_miss);
    assign cc_set = eng_done && !pend_q && !launch_ok;
    assign cbe_set = take;

    // Command write sequence tracker; the array write's address and data are dropped.
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            seq_q <= SEQ_IDLE;
        end else if (ae_set || launch_pv || launch_ok) begin
            seq_q <= SEQ_IDLE;
        end else begin
            case (seq_q)
                SEQ_IDLE: if (wr_arr && cbe_q && !blocked) seq_q <= SEQ_ADDR;
                SEQ_ADDR: if (wr_cmd && cmd_legal && !blocked) seq_q <= SEQ_CMD;
                SEQ_CMD: seq_q <= SEQ_CMD;
                default: seq_q <= SEQ_IDLE;
            endcase
        end
    end

    // Only the writable command bits are stored, so the rest always read zero.
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            cmd_q <= `FMES_RST_CMD;
        end else if (wr_cmd && seq_q == SEQ_ADDR && !blocked) begin
            cmd_q <= bus_in.wdata & `FMES_CMD_WR_MASK;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            prot_q <= `FMES_RST_PROT;
        end else if (wr_prot) begin
            prot_q <= bus_in.wdata;
        end
    end

    // One command may wait behind a running one; the buffer frees when the engine takes it.
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            pend_q <= 1'b0;
            pend_cmd_q <= `FMES_RST_CMD;
        end else if (launch_ok) begin
            pend_q <= 1'b1;
            pend_cmd_q <= cmd_q;
        end else if (take) begin
            pend_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            cbe_q <= 1'b1;
        end else if (cbe_set) begin
            cbe_q <= 1'b1;
        end else if (launch_ok) begin
            cbe_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            cc_q <= 1'b1;
        end else if (cc_set) begin
            cc_q <= 1'b1;
        end else if (launch_ok) begin
            cc_q <= 1'b0;
        end
    end

    // Sticky error flags: a set in the same cycle as a one-write wins.
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            pv_q <= 1'b0;
            ae_q <= 1'b0;
            fail_q <= 1'b0;
        end else begin
            pv_q <= pv_set || (pv_q && !(wr_stat && bus_in.wdata[`FMES_ST_PV]));
            ae_q <= ae_set || (ae_q && !(wr_stat && bus_in.wdata[`FMES_ST_AE]));
            fail_q <= fail_set || (fail_q && !(wr_stat && bus_in.wdata[`FMES_ST_FAIL]));
        end
    end

    // Writes never touch the blank flag; only a verify result or a valid launch does.
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            blank_q <= 1'b0;
        end else if (eng_done && verify_run_q) begin
            blank_q <= all_erased_q && !verify_miss;
        end else if (launch_ok) begin
            blank_q <= 1'b0;
        end
    end

    // Erase and verify engine walking the array one word per cycle.
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            eng_q <= ENG_IDLE;
            walk_q <= 15'h0000;
            verify_run_q <= 1'b0;
        end else begin
            case (eng_q)
                ENG_IDLE: begin
                    walk_q <= 15'h0000;
                    if (take) begin
                        verify_run_q <= (pend_cmd_q == `FMES_CMD_ERASE_VERIFY);
                        eng_q <= (pend_cmd_q == `FMES_CMD_ERASE_VERIFY) ? ENG_VERIFY : ENG_ERASE;
                    end
                end
                ENG_ERASE: begin
                    walk_q <= walk_q + 15'h0001;
                    if (walk_q == LAST_WORD) eng_q <= ENG_IDLE;
                end
                ENG_VERIFY: begin
                    walk_q <= walk_q + 15'h0001;
                    if (walk_q == LAST_WORD) eng_q <= ENG_VLAST;
                end
                ENG_VLAST: if (!arr_q.read) eng_q <= ENG_IDLE;
                default: eng_q <= ENG_IDLE;
            endcase
        end
    end

    // Array strobes are registered so the array sees a clean address with each pulse.
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            arr_q <= '0;
        end else begin
            arr_q.addr <= walk_q;
            arr_q.erase <= (eng_q == ENG_ERASE);
            arr_q.read <= (eng_q == ENG_VERIFY);
        end
    end

    // Read data returns one cycle after each read strobe.
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            rd_vld_q <= 1'b0;
            all_erased_q <= 1'b1;
        end else begin
            rd_vld_q <= arr_q.read;
            if (take) begin
                all_erased_q <= 1'b1;
            end else if (verify_miss) begin
                all_erased_q <= 1'b0;
            end
        end
    end

    always_comb begin
        status = 8'h00;
        status[`FMES_ST_CBE] = cbe_q;
        status[`FMES_ST_CC] = cc_q;
        status[`FMES_ST_PV] = pv_q;
        status[`FMES_ST_AE] = ae_q;
        status[`FMES_ST_BLANK] = blank_q;
        status[`FMES_ST_FAIL] = fail_q;
        status[`FMES_ST_DONE] = spec_q && (eng_q == ENG_IDLE) && !pend_q;
    end

    // Interrupt events; set wins over the one-write clear.
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            irq_stat_q <= `FMES_RST_IRQ;
            irq_mask_q <= `FMES_RST_IRQ;
        end else begin
            if (bus_in.wr && is_reg(bus_in.addr, `FMES_OFF_IRQ_MASK)) begin
                irq_mask_q <= bus_in.wdata[2:0];
            end
            irq_stat_q[`FMES_IRQ_CC] <= cc_set
                || (irq_stat_q[`FMES_IRQ_CC] && !(bus_in.wr && is_reg(bus_in.addr, `FMES_OFF_IRQ_STAT)
                && bus_in.wdata[`FMES_IRQ_CC]));
            irq_stat_q[`FMES_IRQ_CBE] <= cbe_set
                || (irq_stat_q[`FMES_IRQ_CBE] && !(bus_in.wr && is_reg(bus_in.addr, `FMES_OFF_IRQ_STAT)
                && bus_in.wdata[`FMES_IRQ_CBE]));
            irq_stat_q[`FMES_IRQ_ERR] <= (ae_set || pv_set || fail_set)
                || (irq_stat_q[`FMES_IRQ_ERR] && !(bus_in.wr && is_reg(bus_in.addr, `FMES_OFF_IRQ_STAT)
                && bus_in.wdata[`FMES_IRQ_ERR]));
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(irq_stat_q & irq_mask_q);
        end
    end

    // Unmapped and array addresses read as zero.
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            rdata_q <= 8'h00;
        end else if (bus_in.rd) begin
            if (is_reg(bus_in.addr, `FMES_OFF_STAT)) rdata_q <= status;
            else if (is_reg(bus_in.addr, `FMES_OFF_CMD)) rdata_q <= cmd_q;
            else if (is_reg(bus_in.addr, `FMES_OFF_PROT)) rdata_q <= prot_q;
            else if (is_reg(bus_in.addr, `FMES_OFF_IRQ_STAT)) rdata_q <= {5'h00, irq_stat_q};
            else if (is_reg(bus_in.addr, `FMES_OFF_IRQ_MASK)) rdata_q <= {5'h00, irq_mask_q};
            else rdata_q <= 8'h00;
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign rdata_out = rdata_q;
    assign array_out = arr_q;

endmodule
